// ===== hdl/pulse_time_consts.svh
// Constants for the pulse time position output block
`ifndef PULSE_TIME_CONSTS_SVH
`define PULSE_TIME_CONSTS_SVH
`define CLK_PERIOD_NS 8
`define STOP_PULSE_NS 1000000
`define STOP_PULSE_CYC (`STOP_PULSE_NS / `CLK_PERIOD_NS)
`define TRIG_LATENCY_NS 50
`define TRIG_LATENCY_CYC (`TRIG_LATENCY_NS / `CLK_PERIOD_NS)
`define RECIRC_MIN 7'h01
`define RECIRC_MAX 7'h7F
`define RECIRC_DEFAULT 7'h01
`define POS_W 20
`define CNT_W 28
`define IDLE_TIMEOUT_CYC 250000
`define INT_GAP_CYC 16
`endif

// ===== hdl/pulse_time_pkg.sv
// Types for the pulse time position output block
package pulse_time_pkg;
  typedef enum logic [1:0] {
    MODE_START_STOP = 2'h0,
    MODE_WIDTH_EXT = 2'h1,
    MODE_WIDTH_INT = 2'h3
  } out_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DELAY = 2'h1,
    ST_PULSE = 2'h3,
    ST_GAP = 2'h2
  } seq_state_t;
endpackage : pulse_time_pkg

// ===== hdl/pulse_sync.sv
// Two-stage synchroniser with rising edge detect
`timescale 1ns/1ps
`default_nettype none
module pulse_sync (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  // Only sync_r reads meta_r
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign level_out = sync_r;
  assign rise_out = sync_r & ~prev_r;
endmodule : pulse_sync
`default_nettype wire

// ===== hdl/pulse_time_position_output.sv
// Pulse time position output sequencer with status lights
`timescale 1ns/1ps
`default_nettype none
`include "pulse_time_consts.svh"
module pulse_time_position_output
  import pulse_time_pkg::*;
#(
  parameter int STOP_CYC = `STOP_PULSE_CYC,
  parameter int IDLE_CYC = `IDLE_TIMEOUT_CYC
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [1:0] mode_in,
  input wire logic [6:0] recirc_in,
  input wire logic start_in,
  input wire logic [`POS_W-1:0] position_in,
  input wire logic magnet_ok_in,
  input wire logic fault_in,
  output logic pulse_out,
  output logic pulse_oe_n_out,
  output logic led_green_out,
  output logic led_red_out,
  output logic led_yellow_out
);
  logic start_lvl;
  logic start_rise;
  logic [1:0] mode_r;
  logic [6:0] recirc_r;
  logic [`POS_W-1:0] pos_r;
  seq_state_t state_r;
  logic [`CNT_W-1:0] cnt_r;
  logic [`CNT_W-1:0] idle_r;
  logic pulse_r;
  logic trig;
  logic [`CNT_W-1:0] width_nxt;

  pulse_sync u_start_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .async_in(start_in),
    .level_out(start_lvl),
    .rise_out(start_rise)
  );

  // Configuration and position capture; recirculation clamped to legal range
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mode_r <= MODE_START_STOP;
      recirc_r <= `RECIRC_DEFAULT;
      pos_r <= '0;
    end else begin
      mode_r <= mode_in;
      recirc_r <= (recirc_in < `RECIRC_MIN) ? `RECIRC_MIN : recirc_in;
      pos_r <= position_in;
    end
  end

  // Trigger source depends on mode
  assign trig = (mode_r == MODE_WIDTH_INT) ? 1'b1 : start_rise;
  assign width_nxt = `CNT_W'(pos_r) * `CNT_W'(recirc_r);

  // Output sequencer
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      pulse_r <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          pulse_r <= 1'b0;
          if (trig && magnet_ok_in && !fault_in) begin
            if (mode_r == MODE_START_STOP) begin
              state_r <= ST_DELAY;
              cnt_r <= `CNT_W'(pos_r);
            end else begin
              state_r <= ST_PULSE;
              pulse_r <= 1'b1;
              cnt_r <= width_nxt;
            end
          end
        end
        ST_DELAY: begin
          if (cnt_r == '0) begin
            state_r <= ST_PULSE;
            pulse_r <= 1'b1;
            cnt_r <= `CNT_W'(STOP_CYC - 1);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        ST_PULSE: begin
          if (cnt_r == '0) begin
            pulse_r <= 1'b0;
            state_r <= ST_GAP;
            cnt_r <= `CNT_W'(`INT_GAP_CYC);
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        ST_GAP: begin
          if (cnt_r == '0) begin
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          pulse_r <= 1'b0;
        end
      endcase
    end
  end

  // Interrogation watchdog for the yellow light
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      idle_r <= '0;
    end else if (trig || start_lvl) begin
      idle_r <= '0;
    end else if (idle_r != `CNT_W'(IDLE_CYC)) begin
      idle_r <= idle_r + 1'b1;
    end
  end

  // Status lights, one lit at a time
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      led_green_out <= 1'b0;
      led_red_out <= 1'b0;
      led_yellow_out <= 1'b1;
    end else begin
      led_red_out <= fault_in || !magnet_ok_in;
      led_yellow_out <= !fault_in && magnet_ok_in && (idle_r == `CNT_W'(IDLE_CYC));
      led_green_out <= !fault_in && magnet_ok_in && (idle_r != `CNT_W'(IDLE_CYC));
    end
  end

  assign pulse_out = pulse_r;

  // Line driver always driven after reset
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      pulse_oe_n_out <= 1'b1;
    end else begin
      pulse_oe_n_out <= 1'b0;
    end
  end

  // Length of the pulse now on the line and whether a delay led into it, for the checks below
  logic [`CNT_W-1:0] hi_len_r;
  logic from_delay_r;

  // Counts the cycles the output has been high, cleared while low
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      hi_len_r <= '0;
    end else if (pulse_r) begin
      hi_len_r <= hi_len_r + 1'b1;
    end else begin
      hi_len_r <= '0;
    end
  end

  // Set while a start/stop answer runs, so the stop length check knows its pulse
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      from_delay_r <= 1'b0;
    end else if (state_r == ST_DELAY) begin
      from_delay_r <= 1'b1;
    end else if (state_r == ST_IDLE) begin
      from_delay_r <= 1'b0;
    end
  end

  sequence s_stop_start;
    (state_r == ST_DELAY) && (cnt_r == '0);
  endsequence

  sequence s_stop_last;
    (state_r == ST_PULSE) && (cnt_r == '0) && from_delay_r;
  endsequence

  a_stop_begins: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_stop_start |=> pulse_out)
    else $error("stop pulse did not begin");
  a_stop_length: assert property (@(posedge clk_in) disable iff (!resetn_in)
    s_stop_last |-> hi_len_r == `CNT_W'(STOP_CYC - 1))
    else $error("stop pulse length wrong");
  a_width_fast: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_r == ST_IDLE && mode_r == MODE_WIDTH_EXT && start_rise && magnet_ok_in && !fault_in)
    |=> pulse_out)
    else $error("width pulse late");
  a_ss_no_imm: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_r == ST_IDLE && mode_r == MODE_START_STOP) |=> !pulse_out)
    else $error("start stop pulse too early");
  a_internal_rerun: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_r == ST_GAP && cnt_r == '0 && mode_r == MODE_WIDTH_INT) |=> state_r == ST_IDLE)
    else $error("internal trigger stalled");
  a_recirc_legal: assert property (@(posedge clk_in) disable iff (!resetn_in)
    recirc_r >= `RECIRC_MIN)
    else $error("recirculation out of range");
  a_red_fault: assert property (@(posedge clk_in) disable iff (!resetn_in)
    fault_in |=> led_red_out && !led_green_out)
    else $error("red light missing on fault");
  a_one_light: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $onehot({led_green_out, led_red_out, led_yellow_out}))
    else $error("status lights not exclusive");
  a_yellow_idle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!fault_in && magnet_ok_in && idle_r == `CNT_W'(IDLE_CYC)) |=> led_yellow_out)
    else $error("yellow light missing when idle");
  a_ext_only: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_r == ST_IDLE && mode_r == MODE_START_STOP && !start_rise) |=> state_r == ST_IDLE)
    else $error("start stop ran without start");
  a_width_end: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (state_r == ST_PULSE && cnt_r == '0) |=> !pulse_out)
    else $error("pulse did not end");
endmodule : pulse_time_position_output
`default_nettype wire

// ===== tb/ctrl_counter_model.sv
// Controller counter card model that times returned pulses
`timescale 1ns/1ps
`default_nettype none
module ctrl_counter_model #(parameter int HOLD = 6, parameter int TMO = 2000) (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic pulse_in,
  output logic start_out = 1'b0,
  output logic done_out = 1'b0,
  output logic [31:0] result_out = 32'h0
);
  logic [15:0] cnt_r = 16'h0;
  logic [15:0] dly_r = 16'h0;
  logic [15:0] wid_r = 16'h0;
  logic [1:0] st_r = 2'h0;
  // Start held HOLD+1 cycles, a scaled stand-in for the long minimum
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    cnt_r <= cnt_r + 16'h1;
    if (cnt_r == 16'(HOLD)) start_out <= 1'b0;
    case (st_r)
      2'h0: if (go_in) begin
        start_out <= 1'b1;
        cnt_r <= 16'h0;
        st_r <= 2'h1;
      end else if (pulse_in) begin
        dly_r <= 16'h0;
        wid_r <= 16'h1;
        st_r <= 2'h2;
      end
      2'h1: if (pulse_in) begin
        dly_r <= cnt_r;
        wid_r <= 16'h1;
        st_r <= 2'h2;
      end else if (cnt_r == 16'(TMO)) begin
        result_out <= 32'hFFFFFFFF;
        done_out <= 1'b1;
        st_r <= 2'h0;
      end
      default: if (pulse_in && wid_r != 16'(TMO)) wid_r <= wid_r + 16'h1;
      else begin
        result_out <= pulse_in ? 32'hFFFFFFFF : {dly_r, wid_r};
        done_out <= 1'b1;
        st_r <= 2'h0;
      end
    endcase
  end
endmodule : ctrl_counter_model
`default_nettype wire

// ===== tb/pulse_time_position_output_tb.sv
// Self-checking bench for the pulse time position output block
`timescale 1ns/1ps
`default_nettype none
module pulse_time_position_output_tb;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [1:0] mode_in = 2'h1;
  logic [6:0] recirc_in = 7'h01;
  logic [19:0] position_in = 20'h3;
  logic magnet_ok_in = 1'b1;
  logic fault_in = 1'b0;
  logic go = 1'b0;
  logic start, pulse, oe_n, grn, red, yel, done;
  logic [31:0] result;
  logic [15:0] lfsr = 16'h001E;
  logic [31:0] exp_q[$];
  logic [19:0] p;
  logic [6:0] r7;
  int fails = 0;
  int comparisons = 0;
  int k;
  initial forever #4 clk_in = ~clk_in;
  pulse_time_position_output #(.STOP_CYC(10), .IDLE_CYC(1500)) i_pulse_time_position_output (.clk_in(clk_in),
    .resetn_in(resetn_in), .mode_in(mode_in), .recirc_in(recirc_in), .start_in(start), .position_in(position_in),
    .magnet_ok_in(magnet_ok_in), .fault_in(fault_in), .pulse_out(pulse), .pulse_oe_n_out(oe_n),
    .led_green_out(grn), .led_red_out(red), .led_yellow_out(yel));
  ctrl_counter_model i_ctrl_counter_model (.clk_in(clk_in), .go_in(go), .pulse_in(pulse & ~oe_n),
    .start_out(start), .done_out(done), .result_out(result));
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  // Width answer: three cycles of trigger delay, then position times clamped recirculation plus one
  function automatic logic [31:0] exp_width(input logic [19:0] pp, input logic [6:0] r);
    return {16'h3, 16'(pp * 20'((r == 7'h00) ? 7'h01 : r) + 20'h1)};
  endfunction : exp_width
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_led(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk_led
  task automatic print_verdict;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // One interrogation from the controller, expectation noted first
  task automatic meas(input logic [1:0] m, input logic [6:0] r, input logic [31:0] e);
    int n;
    mode_in <= m;
    position_in <= p;
    recirc_in <= r;
    exp_q.push_back(e);
    repeat (3) @(posedge clk_in);
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    for (n = 0; !done && n < 4000; n++) @(posedge clk_in);
    if (!done) fails++;
    repeat (30) @(posedge clk_in);
    lfsr = lfsr_next(lfsr);
    p = 20'(lfsr[2:0]) + 20'h2;
  endtask : meas
  // Each measured result is matched against the oldest note
  always @(posedge clk_in) if (done) begin
    chk(result, exp_q.size() != 0 ? exp_q.pop_front() : 32'hDEADBEEF);
  end
  // Main sequence
  initial begin
    p = 20'h5;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk_led(oe_n, 1'b0);
    repeat (3) meas(2'h0, 7'h01, {16'(p + 4), 16'd10});
    for (int i = 0; i < 4; i++) begin
      r7 = (i == 3) ? lfsr[6:0] : 7'((i * 63) % 190);
      meas(2'h1, r7, exp_width(p, r7));
    end
    chk(exp_q.size(), 32'h0);
    for (k = 0; k < 4; k++) begin
      recirc_in <= k == 0 ? 7'h00 : k == 1 ? 7'h01 : k == 2 ? 7'h7F : 7'h05;
      @(posedge clk_in);
      meas(2'h1, recirc_in, exp_width(p, recirc_in));
      chk_led(grn, 1'b1);
    end
    repeat (3) exp_q.push_back({16'h0, 16'(p * 3 + 1)});
    recirc_in <= 7'h03;
    position_in <= p;
    mode_in <= 2'h3;
    for (k = 0; exp_q.size() != 0 && k < 9000; k++) @(posedge clk_in);
    mode_in <= 2'h1;
    chk(exp_q.size(), 32'h0);
    repeat (1600) @(posedge clk_in);
    chk_led(yel, 1'b1);
    fault_in <= 1'b1;
    meas(2'h1, 7'h01, 32'hFFFFFFFF);
    chk_led(red, 1'b1);
    fault_in <= 1'b0;
    magnet_ok_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    chk_led(red, 1'b1);
    chk(exp_q.size(), 32'h0);
    print_verdict();
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge clk_in);
    fails++;
    print_verdict();
  end
endmodule : pulse_time_position_output_tb
`default_nettype wire
